// [logic/itrg_chan.sv]
// one channel: counting element, initial_value_holding, gate response
`timescale 1ns/100ps
`include "itrg_consts.svh"
module itrg_chan
   import itrg_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // synchronised count clock edge and gate
   input  wire logic        tick,
   input  wire logic        gate,
   input  wire logic        gate_rise,
   // host writes
   input  wire logic        ctrl_wr,
   input  wire logic        data_wr,
   input  wire logic [7:0]  wdata,
   // channel state
   output logic [15:0]      ce,
   output logic             out,
   output logic             null_cnt,
   output itrg_cfg_s        cfg
);
   itrg_core_s  q;
   itrg_core_s  d;
   logic [2:0]  m;
   logic        done;
   logic        ld;
   logic        start;
   logic [15:0] nv;
   logic [15:0] ldv;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   always_comb
   begin
      d = q;
      m = q.cfg.mode[1] ? {1'b0, q.cfg.mode[1:0]} : q.cfg.mode;
      done = 1'b0;
      ld = 1'b0;
      nv = q.cr;
      ldv = (m == 3'h3) ? {q.cr[15:1], 1'b0} : q.cr;
      start = q.load_pend || (q.trig && q.run);
      if (gate_rise)
         d.trig = 1'b1;
      if ((m == 3'h2 || m == 3'h3) && !gate)
         d.out = 1'b1;
      if (tick)
      begin
         d.trig = gate_rise;
         case (m)
            3'h0:
               if (q.load_pend)
                  ld = 1'b1;
               else if (gate)
               begin
                  d.ce = q.ce - `ITRG_STEP_ONE;
                  if (q.ce == `ITRG_STEP_ONE)
                     d.out = 1'b1;
               end
            3'h4:
               if (q.load_pend)
                  ld = 1'b1;
               else
               begin
                  d.out = 1'b1;
                  if (gate && q.run)
                  begin
                     d.ce = q.ce - `ITRG_STEP_ONE;
                     if (q.ce == `ITRG_STEP_ONE)
                     begin
                        d.out = 1'b0;
                        d.run = 1'b0;
                     end
                  end
               end
            3'h1, 3'h5:
               if (q.trig)
               begin
                  ld = 1'b1;
                  d.out = (m == 3'h5);
               end
               else
               begin
                  if (m == 3'h5)
                     d.out = 1'b1;
                  if (q.run)
                  begin
                     d.ce = q.ce - `ITRG_STEP_ONE;
                     if (q.ce == `ITRG_STEP_ONE)
                     begin
                        d.run = 1'b0;
                        d.out = (m == 3'h1);
                     end
                  end
               end
            3'h2:
               if (gate && start)
               begin
                  ld = 1'b1;
                  d.out = 1'b1;
               end
               else if (gate && q.run)
               begin
                  d.ce = q.ce - `ITRG_STEP_ONE;
                  d.out = (q.ce != `ITRG_STEP_TWO);
                  if (q.ce <= `ITRG_STEP_ONE)
                     ld = 1'b1;
               end
            3'h3:
               if (gate && start)
               begin
                  ld = 1'b1;
                  d.out = 1'b1;
               end
               else if (gate && q.run)
               begin
                  if (q.ce <= `ITRG_STEP_TWO)
                  begin
                     ld = 1'b1;
                     d.out = ~q.out;
                  end
                  else
                     d.ce = q.ce - `ITRG_STEP_TWO;
               end
            default:
               ;
         endcase
      end
      if (ld)
      begin
         d.ce = ldv;
         d.run = 1'b1;
         d.load_pend = 1'b0;
         d.null_cnt = 1'b0;
      end
      if (data_wr)
         case (q.cfg.rw)
            ITRG_RW_LSB:
            begin
               nv = {8'h00, wdata};
               done = 1'b1;
            end
            ITRG_RW_MSB:
            begin
               nv = {wdata, 8'h00};
               done = 1'b1;
            end
            ITRG_RW_WORD:
               if (!q.wr_hi)
               begin
                  d.lo = wdata;
                  d.wr_hi = 1'b1;
               end
               else
               begin
                  nv = {wdata, q.lo};
                  d.wr_hi = 1'b0;
                  done = 1'b1;
               end
            default:
               ;
         endcase
      // a write landing on a load keeps the flag set
      if (done)
      begin
         d.cr = nv;
         d.null_cnt = 1'b1;
         if (m == 3'h0 || m == 3'h4 || !q.run)
            d.load_pend = 1'b1;
         if (m == 3'h0)
            d.out = 1'b0;
      end
      if (ctrl_wr)
      begin
         d.cfg = itrg_cfg_s'(wdata[`ITRG_CW_CFG]);
         d.wr_hi = 1'b0;
         d.run = 1'b0;
         d.load_pend = 1'b0;
         d.trig = 1'b0;
         d.null_cnt = 1'b1;
         d.out = (d.cfg.mode != 3'h0);
      end
   end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         q <= '0;
         q.out <= 1'b1;
         q.cfg <= itrg_cfg_s'(`ITRG_CFG_RST);
      end
      else
         q <= d;

   assign ce = q.ce;
   assign out = q.out;
   assign null_cnt = q.null_cnt;
   assign cfg = q.cfg;

   gate_stop_a: assert property (tick && m == 3'h0 && !gate &&
      !q.load_pend && !ctrl_wr |=> $stable(q.ce))
      else $error("count moved with gate low");
   gate_high_a: assert property ((m == 3'h2 || m == 3'h3) && !gate &&
      !ctrl_wr |=> q.out)
      else $error("output not forced high by low gate");
   step_two_a: assert property (tick && m == 3'h3 && gate && q.run &&
      !start && q.ce > 16'h0002 && !ctrl_wr |=> q.ce == $past(q.ce) - 16'h0002)
      else $error("square wave count did not drop by two");
   null_set_a: assert property (ctrl_wr || done |=> q.null_cnt)
      else $error("pending load flag not set");
   null_clr_a: assert property (ld && !ctrl_wr && !done ##1 !ctrl_wr
      |-> !q.null_cnt)
      else $error("pending load flag not cleared on load");
   first_byte_a: assert property (data_wr && q.cfg.rw == ITRG_RW_WORD &&
      !q.wr_hi && !ctrl_wr && !ld |=> $stable(q.null_cnt))
      else $error("first byte changed pending load flag");
endmodule : itrg_chan

// [logic/itrg_consts.svh]
// constants for the interval timer readout and gate block
`ifndef ITRG_CONSTS_SVH
`define ITRG_CONSTS_SVH
`define ITRG_NUM_CH     3
`define ITRG_CTRL_ADDR  2'h3
`define ITRG_CW_SEL     7:6
`define ITRG_CW_RW      5:4
`define ITRG_CW_CFG     5:0
`define ITRG_RB_SEL     2'h3
`define ITRG_RB_CNT_N   5
`define ITRG_RB_STS_N   4
`define ITRG_RB_CH0     1
`define ITRG_RB_ZERO    0
`define ITRG_CFG_RST    6'h10
`define ITRG_UNMAP_RD   8'hFF
`define ITRG_STEP_ONE   16'h0001
`define ITRG_STEP_TWO   16'h0002
`endif

// [logic/itrg_pkg.sv]
// types for the interval timer readout and gate block
package itrg_pkg;
   typedef enum logic [1:0] {
      ITRG_RW_LATCH,
      ITRG_RW_LSB,
      ITRG_RW_MSB,
      ITRG_RW_WORD
   } itrg_rw_e;

   // access_width_high/low, operating_mode_bit2..0, decimal select
   typedef struct packed {
      itrg_rw_e    rw;
      logic [2:0]  mode;
      logic        bcd;
   } itrg_cfg_s;

   typedef struct packed {
      logic [15:0] ce;
      logic [15:0] cr;
      logic [7:0]  lo;
      logic        wr_hi;
      logic        out;
      logic        null_cnt;
      logic        load_pend;
      logic        trig;
      logic        run;
      itrg_cfg_s   cfg;
   } itrg_core_s;

   // count_snapshot_latch and status snapshot of one channel
   typedef struct packed {
      logic        cnt_v;
      logic [15:0] cnt;
      logic        sts_v;
      logic [7:0]  sts;
      logic        rd_hi;
   } itrg_snap_s;

   typedef struct packed {
      logic [2:0]       cs_p;
      logic [2:0]       rd_p;
      logic [2:0]       wr_p;
      logic [2:0][1:0]  a_p;
      logic [2:0][7:0]  d_p;
      logic [2:0][2:0]  ck_p;
      logic [2:0][2:0]  gt_p;
      itrg_snap_s [2:0] snap;
      logic [7:0]       dout;
      logic             oe;
   } itrg_top_s;
endpackage : itrg_pkg

// [logic/itrg_top.sv]
// interval timer readout and gate block: host port, snapshots, channels
`timescale 1ns/100ps
`include "itrg_consts.svh"
module itrg_top
   import itrg_pkg::*;
(
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RST_B,
   // host byte port
   input  wire logic       CS_B,
   input  wire logic       RD_B,
   input  wire logic       WR_B,
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] DATA_IN,
   output logic [7:0]      DATA_OUT,
   output logic            DATA_OE,
   // timer pins
   input  wire logic [2:0] CNT_CLK,
   input  wire logic [2:0] GATE,
   output logic [2:0]      TMR_OUT
);
   itrg_top_s        q;
   itrg_top_s        d;
   logic             wr_ev;
   logic             rd_ev;
   logic             cw;
   logic             rb;
   logic [7:0]       cmd;
   logic [1:0]       adr;
   itrg_snap_s       s;
   logic [15:0]      src;
   logic [7:0]       rv;
   logic [2:0]       lat_w;
   logic [2:0]       ctl_w;
   logic [2:0]       rbc_w;
   logic [2:0]       rbs_w;
   logic [2:0]       dwr_w;
   logic [2:0]       rd_w;
   logic [2:0]       tick_w;
   logic [2:0]       grise_w;
   logic [2:0]       out_w;
   logic [2:0]       null_w;
   logic [2:0][15:0] ce_w;
   logic [2:0][7:0]  sts_w;
   itrg_cfg_s [2:0]  cfg_w;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   always_comb
   begin
      d = q;
      d.cs_p = {q.cs_p[1:0], CS_B};
      d.rd_p = {q.rd_p[1:0], RD_B};
      d.wr_p = {q.wr_p[1:0], WR_B};
      d.a_p = {q.a_p[1:0], ADDR};
      d.d_p = {q.d_p[1:0], DATA_IN};
      d.ck_p = {q.ck_p[1:0], CNT_CLK};
      d.gt_p = {q.gt_p[1:0], GATE};
      // strobes act on their trailing edge
      wr_ev = !q.cs_p[2] && q.wr_p[1] && !q.wr_p[2];
      rd_ev = !q.cs_p[2] && q.rd_p[1] && !q.rd_p[2];
      cmd = q.d_p[2];
      adr = q.a_p[2];
      cw = wr_ev && adr == `ITRG_CTRL_ADDR;
      rb = 1'b0;
      for (int i = 0; i < `ITRG_NUM_CH; i++)
      begin
         lat_w[i] = cw && cmd[`ITRG_CW_SEL] == 2'(i) &&
                    cmd[`ITRG_CW_RW] == ITRG_RW_LATCH;
         ctl_w[i] = cw && cmd[`ITRG_CW_SEL] == 2'(i) &&
                    cmd[`ITRG_CW_RW] != ITRG_RW_LATCH;
         rb = cw && cmd[`ITRG_CW_SEL] == `ITRG_RB_SEL &&
              !cmd[`ITRG_RB_ZERO] && cmd[`ITRG_RB_CH0 + i];
         rbc_w[i] = rb && !cmd[`ITRG_RB_CNT_N];
         rbs_w[i] = rb && !cmd[`ITRG_RB_STS_N];
         dwr_w[i] = wr_ev && adr == 2'(i);
         rd_w[i] = rd_ev && adr == 2'(i);
         tick_w[i] = q.ck_p[2][i] && !q.ck_p[1][i];
         grise_w[i] = q.gt_p[1][i] && !q.gt_p[2][i];
         if (rd_w[i])
         begin
            if (q.snap[i].sts_v)
               d.snap[i].sts_v = 1'b0;
            else if (q.snap[i].cnt_v)
            begin
               if (cfg_w[i].rw == ITRG_RW_WORD && !q.snap[i].rd_hi)
                  d.snap[i].rd_hi = 1'b1;
               else
               begin
                  d.snap[i].cnt_v = 1'b0;
                  d.snap[i].rd_hi = 1'b0;
               end
            end
            else if (cfg_w[i].rw == ITRG_RW_WORD)
               d.snap[i].rd_hi = ~q.snap[i].rd_hi;
         end
         if ((lat_w[i] || rbc_w[i]) && !q.snap[i].cnt_v)
         begin
            d.snap[i].cnt_v = 1'b1;
            d.snap[i].cnt = ce_w[i];
         end
         if (rbs_w[i] && !q.snap[i].sts_v)
         begin
            d.snap[i].sts_v = 1'b1;
            d.snap[i].sts = sts_w[i];
         end
         if (ctl_w[i])
         begin
            d.snap[i].cnt_v = 1'b0;
            d.snap[i].sts_v = 1'b0;
            d.snap[i].rd_hi = 1'b0;
         end
      end
      // byte for the addressed channel; count writes never touch this path
      s = q.snap[0];
      src = ce_w[0];
      rv = `ITRG_UNMAP_RD;
      if (adr != `ITRG_CTRL_ADDR)
      begin
         s = q.snap[adr];
         src = s.cnt_v ? s.cnt : ce_w[adr];
         case (cfg_w[adr].rw)
            ITRG_RW_LSB:
               rv = src[7:0];
            ITRG_RW_MSB:
               rv = src[15:8];
            ITRG_RW_WORD:
               rv = s.rd_hi ? src[15:8] : src[7:0];
            default:
               rv = src[7:0];
         endcase
         if (s.sts_v)
            rv = s.sts;
      end
      d.dout = rv;
      d.oe = !q.cs_p[2] && !q.rd_p[2];
   end

   always_ff @(posedge CLOCK or negedge RST_B)
      if (!RST_B)
      begin
         q <= '0;
         q.cs_p <= '1;
         q.rd_p <= '1;
         q.wr_p <= '1;
         // gate pipe preset high: no false rising edge after reset
         q.gt_p <= '1;
      end
      else
         q <= d;

   assign DATA_OUT = q.dout;
   assign DATA_OE = q.oe;
   assign TMR_OUT = out_w;

   for (genvar g = 0; g < `ITRG_NUM_CH; g++)
   begin : g_ch
      localparam int NX = (g == 2) ? 0 : g + 1;
      itrg_chan u_chan (
         .clk       (CLOCK),
         .rst_b     (RST_B),
         .tick      (tick_w[g]),
         .gate      (q.gt_p[1][g]),
         .gate_rise (grise_w[g]),
         .ctrl_wr   (ctl_w[g]),
         .data_wr   (dwr_w[g]),
         .wdata     (cmd),
         .ce        (ce_w[g]),
         .out       (out_w[g]),
         .null_cnt  (null_w[g]),
         .cfg       (cfg_w[g])
      );
      assign sts_w[g] = {out_w[g], null_w[g], cfg_w[g]};

      latch_grab_a: assert property (lat_w[g] && !q.snap[g].cnt_v
         |=> q.snap[g].cnt_v && q.snap[g].cnt == $past(ce_w[g]))
         else $error("latch command did not capture count");
      latch_keep_a: assert property ((lat_w[g] || rbc_w[g]) &&
         q.snap[g].cnt_v && !rd_w[g] && !ctl_w[g] |=> $stable(q.snap[g].cnt))
         else $error("second count latch overwrote snapshot");
      only_self_a: assert property (rd_w[g] && !lat_w[NX] && !rbc_w[NX] &&
         !ctl_w[NX] |=> $stable(q.snap[NX].cnt_v))
         else $error("read released another channel");
      sts_keep_a: assert property (rbs_w[g] && q.snap[g].sts_v &&
         !ctl_w[g] |=> $stable(q.snap[g].sts) && q.snap[g].sts_v)
         else $error("second status latch overwrote snapshot");
      sts_fmt_a: assert property (rbs_w[g] && !q.snap[g].sts_v
         |=> q.snap[g].sts == {$past(out_w[g]), $past(null_w[g]),
                               $past(cfg_w[g])})
         else $error("status byte layout wrong");
      sts_first_a: assert property (rd_w[g] && q.snap[g].sts_v &&
         q.snap[g].cnt_v |=> !q.snap[g].sts_v && q.snap[g].cnt_v)
         else $error("status not read before count");
      both_latch_a: assert property (rbc_w[g] && rbs_w[g] &&
         !q.snap[g].cnt_v && !q.snap[g].sts_v |=> q.snap[g].cnt_v && q.snap[g].sts_v)
         else $error("combined read-back did not latch both");
      indep_rw_a: assert property (dwr_w[g] |=> $stable(q.snap[g].rd_hi) &&
         $stable(q.snap[g].cnt_v))
         else $error("count write disturbed read sequence");
   end
endmodule : itrg_top

// [tb/itrg_host.sv]
// host bus model: byte port writes and reads with held strobes
`timescale 1ns/100ps
module itrg_host
   import itrg_pkg::*;
(
   // clock
   input  wire logic       clk,
   // byte port toward the timer
   output logic            cs_b,
   output logic            rd_b,
   output logic            wr_b,
   output logic [1:0]      addr,
   output logic [7:0]      data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   // captured read byte, one-cycle strobe
   output logic            rd_stb,
   output logic [7:0]      rd_byte,
   output logic            rd_oe
);
   initial
   begin
      cs_b = 1'b1;
      rd_b = 1'b1;
      wr_b = 1'b1;
      addr = 2'h0;
      data_in = 8'h00;
      rd_stb = 1'b0;
      rd_byte = 8'h00;
      rd_oe = 1'b0;
   end

   // commands carry read-back and latch layouts as the caller builds them
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      cs_b <= 1'b0;
      wr_b <= 1'b0;
      addr <= a;
      data_in <= d;
      repeat (6) @(posedge clk);
      wr_b <= 1'b1;
      repeat (4) @(posedge clk);
      cs_b <= 1'b1;
      data_in <= ~d;
      repeat (6) @(posedge clk);
   endtask : wr

   // callers only read latched values, halted channels or the unmapped control address
   task automatic rd(input logic [1:0] a);
      @(posedge clk);
      cs_b <= 1'b0;
      rd_b <= 1'b0;
      addr <= a;
      repeat (7) @(posedge clk);
      rd_byte <= data_out;
      rd_oe <= data_oe;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      rd_b <= 1'b1;
      repeat (4) @(posedge clk);
      cs_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : rd
endmodule : itrg_host

// [tb/tb.sv]
// testbench: snapshots, status, gate response and step size
`timescale 1ns/100ps
module tb
   import itrg_pkg::*;
;
   logic        CLOCK;
   logic        RST_B;
   logic        CS_B;
   logic        RD_B;
   logic        WR_B;
   logic [1:0]  ADDR;
   logic [7:0]  DATA_IN;
   logic [7:0]  DATA_OUT;
   logic        DATA_OE;
   logic [2:0]  CNT_CLK;
   logic [2:0]  GATE;
   logic [2:0]  TMR_OUT;
   logic        rd_stb;
   logic [7:0]  rd_byte;
   logic        rd_oe;
   logic [7:0]  exp_q[$];
   logic [31:0] lfsr;
   logic [15:0] n0;
   logic [15:0] n1;
   logic [15:0] n2;
   logic [15:0] cur;
   int          n_errors;
   int          n_tests;

   itrg_top dut (.CLOCK(CLOCK), .RST_B(RST_B), .CS_B(CS_B), .RD_B(RD_B),
      .WR_B(WR_B), .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
      .DATA_OE(DATA_OE), .CNT_CLK(CNT_CLK), .GATE(GATE),
      .TMR_OUT(TMR_OUT));

   itrg_host host (.clk(CLOCK), .cs_b(CS_B), .rd_b(RD_B), .wr_b(WR_B),
      .addr(ADDR), .data_in(DATA_IN), .data_out(DATA_OUT),
      .data_oe(DATA_OE), .rd_stb(rd_stb), .rd_byte(rd_byte),
      .rd_oe(rd_oe));

   initial
   begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic rnd16(output logic [15:0] v);
      repeat (16) lfsr = lfsr_next(lfsr);
      v = lfsr[15:0];
   endtask : rnd16

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // note one expected byte, then read it
   task automatic exp_rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : exp_rd

   // two-byte count, low byte first
   task automatic exp_cnt(input logic [1:0] a, input logic [15:0] e);
      exp_rd(a, e[7:0]);
      exp_rd(a, e[15:8]);
   endtask : exp_cnt

   task automatic wr_cnt(input logic [1:0] a, input logic [15:0] v);
      host.wr(a, v[7:0]);
      host.wr(a, v[15:8]);
   endtask : wr_cnt

   // one falling edge on the selected count clocks
   task automatic tick(input logic [2:0] m);
      @(posedge CLOCK);
      CNT_CLK <= ~m;
      repeat (4) @(posedge CLOCK);
      CNT_CLK <= 3'h7;
      repeat (6) @(posedge CLOCK);
   endtask : tick

   always @(posedge CLOCK)
   begin
      if (rd_stb === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected read", 8'h00, 8'h01);
         else
         begin
            check("data enable", {7'h00, rd_oe}, 8'h01);
            check("read byte", rd_byte, exp_q.pop_front());
         end
      end
   end

   initial
   begin
      repeat (60000) @(posedge CLOCK);
      check("run time", 8'h00, 8'h01);
      give_verdict();
   end

   initial
   begin
      RST_B = 1'b0;
      CNT_CLK = 3'h7;
      GATE = 3'h7;
      n_errors = 0;
      n_tests = 0;
      lfsr = 32'hBFD1;
      repeat (3) @(posedge CLOCK);
      RST_B <= 1'b1;
      rnd16(n0);
      n0 = (n0 & 16'h7FFF) | 16'h1000;
      host.wr(2'h3, 8'h34);
      wr_cnt(2'h0, n0);
      host.wr(2'h3, 8'hE2);
      tick(3'h1);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'hF4);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'hB4);
      host.wr(2'h3, 8'h00);
      tick(3'h1);
      tick(3'h1);
      host.wr(2'h3, 8'h0F);
      exp_cnt(2'h0, n0);
      cur = n0 - 16'h0002;
      host.wr(2'h3, 8'hD2);
      tick(3'h1);
      host.wr(2'h3, 8'hD2);
      exp_cnt(2'h0, cur);
      cur = cur - 16'h0001;
      rnd16(n1);
      host.wr(2'h0, n1[7:0]);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'hB4);
      host.wr(2'h3, 8'h00);
      exp_rd(2'h0, cur[7:0]);
      host.wr(2'h0, n1[15:8]);
      exp_rd(2'h0, cur[15:8]);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'hF4);
      host.wr(2'h3, 8'hC2);
      exp_rd(2'h0, 8'hF4);
      exp_cnt(2'h0, cur);
      host.wr(2'h3, 8'hD2);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'hF4);
      exp_cnt(2'h0, cur);
      rnd16(n1);
      n1 = (n1 & 16'h7FFF) | 16'h1000;
      host.wr(2'h3, 8'h74);
      wr_cnt(2'h1, n1);
      tick(3'h2);
      host.wr(2'h3, 8'hD6);
      tick(3'h3);
      exp_cnt(2'h1, n1);
      host.wr(2'h3, 8'hD4);
      exp_cnt(2'h1, n1 - 16'h0001);
      exp_cnt(2'h0, cur);
      @(posedge CLOCK);
      GATE[1] <= 1'b0;
      repeat (8) @(posedge CLOCK);
      check("forced output", {7'h00, TMR_OUT[1]}, 8'h01);
      tick(3'h2);
      tick(3'h2);
      host.wr(2'h3, 8'h40);
      exp_cnt(2'h1, n1 - 16'h0001);
      GATE[1] <= 1'b1;
      repeat (8) @(posedge CLOCK);
      tick(3'h2);
      host.wr(2'h3, 8'h40);
      exp_cnt(2'h1, n1);
      rnd16(n2);
      n2 = (n2 & 16'h7FFE) | 16'h1000;
      host.wr(2'h3, 8'hB6);
      wr_cnt(2'h2, n2);
      tick(3'h4);
      tick(3'h4);
      host.wr(2'h3, 8'h80);
      exp_cnt(2'h2, n2 - 16'h0002);
      host.wr(2'h3, 8'hB6);
      wr_cnt(2'h2, 16'h0004);
      repeat (3) tick(3'h4);
      check("square toggle", {7'h00, TMR_OUT[2]}, 8'h00);
      GATE[2] <= 1'b0;
      repeat (8) @(posedge CLOCK);
      check("gate forces high", {7'h00, TMR_OUT[2]}, 8'h01);
      GATE[2] <= 1'b1;
      host.wr(2'h3, 8'h10);
      host.wr(2'h0, 8'h05);
      repeat (2) tick(3'h1);
      GATE[0] <= 1'b0;
      repeat (8) @(posedge CLOCK);
      tick(3'h1);
      host.wr(2'h3, 8'h00);
      exp_rd(2'h0, 8'h04);
      host.wr(2'h3, 8'hE2);
      exp_rd(2'h0, 8'h10);
      GATE[0] <= 1'b1;
      repeat (4) tick(3'h1);
      check("terminal output", {7'h00, TMR_OUT[0]}, 8'h01);
      host.wr(2'h3, 8'h6A);
      host.wr(2'h1, 8'h02);
      GATE[1] <= 1'b0;
      repeat (8) @(posedge CLOCK);
      GATE[1] <= 1'b1;
      repeat (8) @(posedge CLOCK);
      repeat (2) tick(3'h2);
      host.wr(2'h3, 8'h40);
      exp_rd(2'h1, 8'h01);
      exp_rd(2'h3, 8'hFF);
      for (int i = 0; i < 50 && exp_q.size() != 0; i++)
         @(posedge CLOCK);
      if (exp_q.size() != 0)
         check("pending reads", 8'h00, 8'h01);
      check("data idle", {7'h00, DATA_OE}, 8'h00);
      give_verdict();
   end
endmodule : tb
